// >>> hw/tlic_pkg.sv
// Constants for the two-level interrupt collector: register map, field layouts, reset values
// What this block does
// RULE1: gather peripheral requests, drive three maskable levels and one non-maskable line
// RULE2: all enable registers reset to zero so nothing reaches the core
// RULE3: a raised peripheral request sets its second-level pending bit
// RULE4: second-level pending is ANDed with its enable before going upward
// RULE5: enabled requests of one second-level register merge into one first-level bit
// RULE6: some sources set their first-level status bit directly
// RULE7: first-level status ANDed with first-level enable gates every core output
// RULE8: battery-low request goes to non-maskable line or level 0, by route select
// RULE9: route bit 0 high sends battery to level 0, low to non-maskable
// RULE10: long timer 1 alone drives level 1, long timer 2 alone drives level 2
// RULE11: all other enabled first-level requests are ORed onto level 0
// RULE12: software routes battery to level 0 when it must be maskable
// RULE13: in suspend keep masking, drive any-interrupt wake and memory-drive timing
// RULE14: decode processor read and write addresses onto the addressed register
// RULE15: status A bits: 12 clock-run, 11 soft, 9 serial, 8 gpio, 3,2,1,0 sources
// RULE16: enable A writable at status A positions, 1 enables, other bits read-only
// RULE17: status A bit 11 is set by writing the software request register
// RULE18: gpio low pending holds pins 13..0 and pin 15; bit 14 reserved
// RULE19: gpio low enable writable for pins 15 and 13..0 at same positions
// RULE20: debug serial pending uses bit 11 only, other bits reserved
// RULE21: reserved bits always read zero; software writes zero to them
// RULE22: pending registers read-only; enable, route and soft registers read-write
// RULE23: pending bits follow request level; reads never clear them
package tlic_pkg;
   // Register byte addresses
   localparam logic [31:0] ADDR_SYS_STATUS_A   = 32'h0f00_0080;
   localparam logic [31:0] ADDR_GPIO_LOW_PEND  = 32'h0f00_0088;
   localparam logic [31:0] ADDR_DSER_PEND      = 32'h0f00_008a;
   localparam logic [31:0] ADDR_SYS_ENABLE_A   = 32'h0f00_008c;
   localparam logic [31:0] ADDR_GPIO_LOW_EN    = 32'h0f00_0094;
   localparam logic [31:0] ADDR_DSER_EN        = 32'h0f00_0096;
   localparam logic [31:0] ADDR_BATT_ROUTE     = 32'h0f00_0098;
   localparam logic [31:0] ADDR_SOFT_REQ       = 32'h0f00_009a;
   localparam logic [31:0] ADDR_SYS_STATUS_B   = 32'h0f00_00a0;
   localparam logic [31:0] ADDR_GPIO_HIGH_PEND = 32'h0f00_00a2;
   localparam logic [31:0] ADDR_IR_PEND        = 32'h0f00_00a4;
   localparam logic [31:0] ADDR_SYS_ENABLE_B   = 32'h0f00_00a6;
   localparam logic [31:0] ADDR_GPIO_HIGH_EN   = 32'h0f00_00a8;
   localparam logic [31:0] ADDR_IR_EN          = 32'h0f00_00aa;
   localparam logic [31:0] ADDR_PCI_PEND       = 32'h0f00_00ac;
   localparam logic [31:0] ADDR_SCU_PEND       = 32'h0f00_00ae;
   localparam logic [31:0] ADDR_SSER_PEND      = 32'h0f00_00b0;
   localparam logic [31:0] ADDR_PCI_EN         = 32'h0f00_00b2;
   localparam logic [31:0] ADDR_SCU_EN         = 32'h0f00_00b4;
   localparam logic [31:0] ADDR_SSER_EN        = 32'h0f00_00b6;
   localparam logic [31:0] ADDR_BUS_PEND       = 32'h0f00_00b8;
   localparam logic [31:0] ADDR_BUS_EN         = 32'h0f00_00ba;
   // Implemented bits; all others are reserved and read zero
   localparam logic [15:0] SYS_A_BITS     = 16'h1b0f;
   localparam logic [15:0] SYS_B_BITS     = 16'h03fb;
   localparam logic [15:0] GPIO_LOW_BITS  = 16'hbfff;
   localparam logic [15:0] GPIO_HIGH_BITS = 16'hffff;
   localparam logic [15:0] DSER_BITS      = 16'h0800;
   localparam logic [15:0] IR_BITS        = 16'h001f;
   localparam logic [15:0] ONE_BIT        = 16'h0001;
   localparam logic [15:0] SSER_BITS      = 16'h00ff;
   localparam logic [15:0] SOFT_BITS      = 16'h000f;
   localparam logic [15:0] ENABLE_RESET   = 16'h0000;
   localparam logic [15:0] PEND_RESET     = 16'h0000;
   // Status A bit positions
   localparam int A_BATTERY = 0;
   localparam int A_POWER   = 1;
   localparam int A_RTC1    = 2;
   localparam int A_ETIMER  = 3;
   localparam int A_GPIO    = 8;
   localparam int A_SERIAL  = 9;
   localparam int A_SOFT    = 11;
   localparam int A_CLKRUN  = 12;
   // Status B bit positions
   localparam int B_RTC2 = 0;
   localparam int B_LED  = 1;
   localparam int B_TCLK = 3;
   localparam int B_IR   = 4;
   localparam int B_DSER = 5;
   localparam int B_PCI  = 6;
   localparam int B_SCU  = 7;
   localparam int B_SSER = 8;
   localparam int B_BUS  = 9;
   // Debug serial pending bit and route select bit
   localparam int DSER_BIT  = 11;
   localparam int ROUTE_BIT = 0;
   // Bits kept out of the level 0 OR; battery bit 0 reaches level 0 only by route select
   localparam logic [15:0] A_NOT_LEVEL0 = 16'h0005;
   localparam logic [15:0] B_NOT_LEVEL0 = 16'h0001;
endpackage

// >>> hw/tlic_top.sv
// Two-level interrupt collector: pending, enable, routing and core request outputs
`timescale 1ns/1ps
`default_nettype none
module tlic_top (
   // System
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire logic        suspendMode,
   // Register access from the core
   input  wire logic [31:0] regAddr,
   input  wire logic        regRead,
   input  wire logic        regWrite,
   input  wire logic [15:0] regWdata,
   output var  logic [15:0] regRdata,
   output var  logic        regRdValid,
   // Direct first-level sources
   input  wire logic        clock_run_request,
   input  wire logic        serial_unit_request,
   input  wire logic        elapsed_timer_request,
   input  wire logic        rtc_long_one_line,
   input  wire logic        power_switch_request,
   input  wire logic        battery_low_request,
   input  wire logic        rtc_long_two_line,
   input  wire logic        ledRequest,
   input  wire logic        tclkRequest,
   // Second-level sources
   input  wire logic [15:0] gpioLowReq,
   input  wire logic [15:0] gpioHighReq,
   input  wire logic        debug_serial_request,
   input  wire logic [4:0]  infraredReq,
   input  wire logic        pciRequest,
   input  wire logic        scuRequest,
   input  wire logic [7:0]  syncSerialReq,
   input  wire logic        busCtrlRequest,
   // Core request outputs
   output var  logic        core_irq_level0,
   output var  logic        core_irq_level1,
   output var  logic        core_irq_level2,
   output var  logic        coreNmi,
   output var  logic        anyIrqAll,
   output var  logic        memDrive
);

   // Pending (indication) registers, level-following
   logic [15:0] directA;
   logic [15:0] directB;
   logic [15:0] gpio_low_pending;
   logic [15:0] gpio_high_pending;
   logic [15:0] debug_serial_pending;
   logic [15:0] infrared_pending;
   logic [15:0] pci_pending;
   logic [15:0] sc_unit_pending;
   logic [15:0] sync_serial_pending;
   logic [15:0] bus_ctrl_pending;
   // Software-writable registers
   logic [15:0] sys_enable_level1_a;
   logic [15:0] sys_enable_level1_b;
   logic [15:0] gpio_low_enable;
   logic [15:0] gpio_high_enable;
   logic [15:0] debug_serial_enable;
   logic [15:0] infrared_enable;
   logic [15:0] pci_enable;
   logic [15:0] sc_unit_enable;
   logic [15:0] sync_serial_enable;
   logic [15:0] bus_ctrl_enable;
   logic [15:0] battery_route_select;
   logic [15:0] soft_request;
   // Derived
   logic [15:0] sys_status_level1_a;
   logic [15:0] sys_status_level1_b;
   logic [15:0] activeA;
   logic [15:0] activeB;
   logic        next_level0;
   logic        next_level1;
   logic        next_level2;
   logic        next_nmi;
   logic        next_any;
   logic [15:0] next_rdata;
   logic        wrEn;

   assign wrEn = ce && regWrite;

   // Peripherals share this clock, so requests are sampled without synchronisers.
   // Pending bits track the request level; only the source withdrawing it clears a bit.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         directA              <= tlic_pkg::PEND_RESET;
         directB              <= tlic_pkg::PEND_RESET;
         gpio_low_pending     <= tlic_pkg::PEND_RESET;
         gpio_high_pending    <= tlic_pkg::PEND_RESET;
         debug_serial_pending <= tlic_pkg::PEND_RESET;
         infrared_pending     <= tlic_pkg::PEND_RESET;
         pci_pending          <= tlic_pkg::PEND_RESET;
         sc_unit_pending      <= tlic_pkg::PEND_RESET;
         sync_serial_pending  <= tlic_pkg::PEND_RESET;
         bus_ctrl_pending     <= tlic_pkg::PEND_RESET;
      end else if (ce) begin
         // Direct sources skip the second level [RULE6] [RULE15]
         directA <= '0;
         directA[tlic_pkg::A_CLKRUN]  <= clock_run_request;
         directA[tlic_pkg::A_SERIAL]  <= serial_unit_request;
         directA[tlic_pkg::A_ETIMER]  <= elapsed_timer_request;
         directA[tlic_pkg::A_RTC1]    <= rtc_long_one_line;
         directA[tlic_pkg::A_POWER]   <= power_switch_request;
         directA[tlic_pkg::A_BATTERY] <= battery_low_request;
         directB <= '0;
         directB[tlic_pkg::B_RTC2] <= rtc_long_two_line;
         directB[tlic_pkg::B_LED]  <= ledRequest;
         directB[tlic_pkg::B_TCLK] <= tclkRequest;
         // Second-level indication, reserved bits forced low [RULE3] [RULE18] [RULE20] [RULE23]
         gpio_low_pending  <= gpioLowReq & tlic_pkg::GPIO_LOW_BITS;
         gpio_high_pending <= gpioHighReq & tlic_pkg::GPIO_HIGH_BITS;
         debug_serial_pending <= '0;
         debug_serial_pending[tlic_pkg::DSER_BIT] <= debug_serial_request;
         infrared_pending    <= {11'h000, infraredReq};
         pci_pending         <= {15'h0000, pciRequest};
         sc_unit_pending     <= {15'h0000, scuRequest};
         sync_serial_pending <= {8'h00, syncSerialReq};
         bus_ctrl_pending    <= {15'h0000, busCtrlRequest};
      end
   end

   // Enable, route and software registers; writes keep only implemented bits [RULE2] [RULE21]
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sys_enable_level1_a  <= tlic_pkg::ENABLE_RESET;
         sys_enable_level1_b  <= tlic_pkg::ENABLE_RESET;
         gpio_low_enable      <= tlic_pkg::ENABLE_RESET;
         gpio_high_enable     <= tlic_pkg::ENABLE_RESET;
         debug_serial_enable  <= tlic_pkg::ENABLE_RESET;
         infrared_enable      <= tlic_pkg::ENABLE_RESET;
         pci_enable           <= tlic_pkg::ENABLE_RESET;
         sc_unit_enable       <= tlic_pkg::ENABLE_RESET;
         sync_serial_enable   <= tlic_pkg::ENABLE_RESET;
         bus_ctrl_enable      <= tlic_pkg::ENABLE_RESET;
         battery_route_select <= tlic_pkg::ENABLE_RESET;
         soft_request         <= tlic_pkg::ENABLE_RESET;
      end else if (wrEn) begin
         // Writes to pending addresses fall to the default and change nothing [RULE14] [RULE22]
         case (regAddr)
            tlic_pkg::ADDR_SYS_ENABLE_A: begin
               sys_enable_level1_a <= regWdata & tlic_pkg::SYS_A_BITS;       // [RULE16]
            end
            tlic_pkg::ADDR_SYS_ENABLE_B: begin
               sys_enable_level1_b <= regWdata & tlic_pkg::SYS_B_BITS;
            end
            tlic_pkg::ADDR_GPIO_LOW_EN: begin
               gpio_low_enable <= regWdata & tlic_pkg::GPIO_LOW_BITS;        // [RULE19]
            end
            tlic_pkg::ADDR_GPIO_HIGH_EN: begin
               gpio_high_enable <= regWdata & tlic_pkg::GPIO_HIGH_BITS;
            end
            tlic_pkg::ADDR_DSER_EN: begin
               debug_serial_enable <= regWdata & tlic_pkg::DSER_BITS;
            end
            tlic_pkg::ADDR_IR_EN: begin
               infrared_enable <= regWdata & tlic_pkg::IR_BITS;
            end
            tlic_pkg::ADDR_PCI_EN: begin
               pci_enable <= regWdata & tlic_pkg::ONE_BIT;
            end
            tlic_pkg::ADDR_SCU_EN: begin
               sc_unit_enable <= regWdata & tlic_pkg::ONE_BIT;
            end
            tlic_pkg::ADDR_SSER_EN: begin
               sync_serial_enable <= regWdata & tlic_pkg::SSER_BITS;
            end
            tlic_pkg::ADDR_BUS_EN: begin
               bus_ctrl_enable <= regWdata & tlic_pkg::ONE_BIT;
            end
            tlic_pkg::ADDR_BATT_ROUTE: begin
               battery_route_select <= regWdata & tlic_pkg::ONE_BIT;         // [RULE9]
            end
            tlic_pkg::ADDR_SOFT_REQ: begin
               // Four request bits; software both sets and clears them [RULE17]
               soft_request <= regWdata & tlic_pkg::SOFT_BITS;
            end
            default: begin
            end
         endcase
      end
   end

   // First-level status: mask each group, fold it to one bit [RULE4] [RULE5]
   always_comb begin
      sys_status_level1_a = directA;
      sys_status_level1_a[tlic_pkg::A_GPIO] = |((gpio_low_pending & gpio_low_enable)
                                              | (gpio_high_pending & gpio_high_enable));
      sys_status_level1_a[tlic_pkg::A_SOFT] = |soft_request;                   // [RULE17]
      sys_status_level1_b = directB;
      sys_status_level1_b[tlic_pkg::B_IR]   = |(infrared_pending & infrared_enable);
      sys_status_level1_b[tlic_pkg::B_DSER] = |(debug_serial_pending & debug_serial_enable);
      sys_status_level1_b[tlic_pkg::B_PCI]  = |(pci_pending & pci_enable);
      sys_status_level1_b[tlic_pkg::B_SCU]  = |(sc_unit_pending & sc_unit_enable);
      sys_status_level1_b[tlic_pkg::B_SSER] = |(sync_serial_pending & sync_serial_enable);
      sys_status_level1_b[tlic_pkg::B_BUS]  = |(bus_ctrl_pending & bus_ctrl_enable);
   end

   // Output routing; the battery enable gates both routes, so the non-maskable
   // path is still quiet until software enables the source [RULE7]
   always_comb begin
      activeA = sys_status_level1_a & sys_enable_level1_a;
      activeB = sys_status_level1_b & sys_enable_level1_b;
      next_nmi = activeA[tlic_pkg::A_BATTERY]
               && !battery_route_select[tlic_pkg::ROUTE_BIT];                  // [RULE8]
      next_level1 = activeA[tlic_pkg::A_RTC1];                                 // [RULE10]
      next_level2 = activeB[tlic_pkg::B_RTC2];                                 // [RULE10]
      next_level0 = (activeA[tlic_pkg::A_BATTERY]
                     && battery_route_select[tlic_pkg::ROUTE_BIT])             // [RULE9]
                  || |(activeA & ~tlic_pkg::A_NOT_LEVEL0)
                  || |(activeB & ~tlic_pkg::B_NOT_LEVEL0);                    // [RULE11]
      next_any = next_level0 || next_level1 || next_level2 || next_nmi;
   end

   // Core outputs registered; masking stays in force while suspended [RULE1] [RULE13]
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         core_irq_level0 <= 1'b0;
         core_irq_level1 <= 1'b0;
         core_irq_level2 <= 1'b0;
         coreNmi         <= 1'b0;
         anyIrqAll       <= 1'b0;
      end else if (ce) begin
         core_irq_level0 <= next_level0;
         core_irq_level1 <= next_level1;
         core_irq_level2 <= next_level2;
         coreNmi         <= next_nmi;
         anyIrqAll       <= next_any;
      end
   end

   // Memory drive timing: one pulse when an enabled request first appears in suspend,
   // so memory drivers come up once per wake, not for every later request [RULE13]
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         memDrive <= 1'b0;
      end else if (ce) begin
         memDrive <= suspendMode && next_any && !anyIrqAll;
      end
   end

   // Read decode; pending registers read without side effects [RULE14] [RULE22] [RULE23]
   always_comb begin
      case (regAddr)
         tlic_pkg::ADDR_SYS_STATUS_A:   next_rdata = sys_status_level1_a;
         tlic_pkg::ADDR_GPIO_LOW_PEND:  next_rdata = gpio_low_pending;
         tlic_pkg::ADDR_DSER_PEND:      next_rdata = debug_serial_pending;
         tlic_pkg::ADDR_SYS_ENABLE_A:   next_rdata = sys_enable_level1_a;
         tlic_pkg::ADDR_GPIO_LOW_EN:    next_rdata = gpio_low_enable;
         tlic_pkg::ADDR_DSER_EN:        next_rdata = debug_serial_enable;
         tlic_pkg::ADDR_BATT_ROUTE:     next_rdata = battery_route_select;
         tlic_pkg::ADDR_SOFT_REQ:       next_rdata = soft_request;
         tlic_pkg::ADDR_SYS_STATUS_B:   next_rdata = sys_status_level1_b;
         tlic_pkg::ADDR_GPIO_HIGH_PEND: next_rdata = gpio_high_pending;
         tlic_pkg::ADDR_IR_PEND:        next_rdata = infrared_pending;
         tlic_pkg::ADDR_SYS_ENABLE_B:   next_rdata = sys_enable_level1_b;
         tlic_pkg::ADDR_GPIO_HIGH_EN:   next_rdata = gpio_high_enable;
         tlic_pkg::ADDR_IR_EN:          next_rdata = infrared_enable;
         tlic_pkg::ADDR_PCI_PEND:       next_rdata = pci_pending;
         tlic_pkg::ADDR_SCU_PEND:       next_rdata = sc_unit_pending;
         tlic_pkg::ADDR_SSER_PEND:      next_rdata = sync_serial_pending;
         tlic_pkg::ADDR_PCI_EN:         next_rdata = pci_enable;
         tlic_pkg::ADDR_SCU_EN:         next_rdata = sc_unit_enable;
         tlic_pkg::ADDR_SSER_EN:        next_rdata = sync_serial_enable;
         tlic_pkg::ADDR_BUS_PEND:       next_rdata = bus_ctrl_pending;
         tlic_pkg::ADDR_BUS_EN:         next_rdata = bus_ctrl_enable;
         default:                       next_rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         regRdata   <= 16'h0000;
         regRdValid <= 1'b0;
      end else if (ce) begin
         regRdValid <= regRead;
         if (regRead) begin
            regRdata <= next_rdata;
         end
      end
   end

   // Checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   AST_ENABLE_AFTER_RESET: assert property (  // [RULE2]
      $rose(nrst) |-> sys_enable_level1_a == 16'h0000
      && gpio_low_enable == 16'h0000 && sys_enable_level1_b == 16'h0000)
      else $error("enable register not zero after reset");
   AST_PEND_FOLLOWS: assert property (  // [RULE23]
      ce |=> gpio_low_pending == ($past(gpioLowReq) & tlic_pkg::GPIO_LOW_BITS))
      else $error("gpio low pending does not follow request level");
   AST_DSER_SET: assert property (  // [RULE3]
      ce && debug_serial_request
      |=> debug_serial_pending == tlic_pkg::DSER_BITS)
      else $error("debug serial pending not set");
   AST_RESERVED_ZERO: assert property (  // [RULE21]
      gpio_low_pending[14] == 1'b0 && sys_enable_level1_a[15:13] == 3'h0
      && battery_route_select[15:1] == 15'h0000)
      else $error("reserved bit not zero");
   AST_GPIO_MASKED: assert property (  // [RULE5]
      ce && (gpio_low_pending & gpio_low_enable) != 16'h0000
      && sys_enable_level1_a[tlic_pkg::A_GPIO] |=> core_irq_level0)
      else $error("enabled gpio request did not reach level 0");
   AST_MASK_BLOCKS: assert property (  // [RULE7]
      ce && sys_enable_level1_a == 16'h0000 && sys_enable_level1_b == 16'h0000
      |=> !core_irq_level0 && !core_irq_level1 && !core_irq_level2 && !coreNmi)
      else $error("request reached core while masked");
   AST_BATT_NMI: assert property (  // [RULE8]
      ce && sys_status_level1_a[0] && sys_enable_level1_a[0]
      && !battery_route_select[0] |=> coreNmi)
      else $error("battery not routed to non-maskable line");
   AST_BATT_LEVEL0: assert property (  // [RULE9]
      ce && battery_route_select[0] |=> !coreNmi)
      else $error("non-maskable line active with level 0 route");
   // Two enabled edges separate the timer input from level 1
   AST_TIMER1_ONLY: assert property (  // [RULE10]
      $past(ce) && $past(ce, 2) && core_irq_level1
      |-> $past(rtc_long_one_line, 2))
      else $error("level 1 without long timer 1 request");
   AST_TIMER2: assert property (  // [RULE10]
      ce && sys_status_level1_b[0] && sys_enable_level1_b[0]
      |=> core_irq_level2)
      else $error("long timer 2 did not drive level 2");
   AST_SOFT_SET: assert property (  // [RULE17]
      wrEn && regAddr == tlic_pkg::ADDR_SOFT_REQ && regWdata[3:0] != 4'h0
      |=> sys_status_level1_a[tlic_pkg::A_SOFT])
      else $error("software request not shown in status");
   AST_READ_ENABLE: assert property (  // [RULE14]
      ce && regRead && regAddr == tlic_pkg::ADDR_SYS_ENABLE_A
      |=> regRdValid && regRdata == $past(sys_enable_level1_a))
      else $error("read of enable register wrong");
   AST_RO_WRITE: assert property (  // [RULE22]
      wrEn && regAddr == tlic_pkg::ADDR_SYS_STATUS_A
      |=> $stable(sys_enable_level1_a) && $stable(soft_request))
      else $error("write to status register changed state");
   AST_SUSPEND_WAKE: assert property (  // [RULE13]
      ce && suspendMode && !anyIrqAll && next_any
      |=> memDrive && anyIrqAll)
      else $error("no wake or memory drive pulse in suspend");

   // The wake line is the OR of the four core lines, registered on the same edge
   AST_ANY_OR: assert property (  // [RULE13]
      anyIrqAll == (core_irq_level0 || core_irq_level1 || core_irq_level2 || coreNmi))
      else $error("any-interrupt line differs from the core lines");
   // A low clock enable must hold every flop, the register file included
   AST_CE_FREEZE: assert property (  // [RULE1]
      !ce |=> $stable(core_irq_level0) && $stable(anyIrqAll) && $stable(gpio_low_pending)
      && $stable(sys_enable_level1_a))
      else $error("state moved while the clock enable was low");
   AST_GROUPB_FOLD: assert property (  // [RULE11]
      ce && (infrared_pending & infrared_enable) != 16'h0000
      && sys_enable_level1_b[tlic_pkg::B_IR] |=> core_irq_level0)
      else $error("enabled infrared request did not reach level 0");
   AST_STATUS_A_DIRECT: assert property (  // [RULE15]
      ce |=> sys_status_level1_a[tlic_pkg::A_CLKRUN] == $past(clock_run_request)
      && sys_status_level1_a[tlic_pkg::A_POWER] == $past(power_switch_request))
      else $error("direct source not shown in status A");
   // Read data stands until the next taken read, so the core may sample it late
   AST_RDATA_HOLD: assert property (  // [RULE14]
      ce && !regRead |=> !regRdValid && $stable(regRdata))
      else $error("read data moved without a read");

   // Main scenarios the bench should reach
   COV_BATT_NMI: cover property (coreNmi);
   COV_BATT_LEVEL0: cover property (core_irq_level0 && battery_route_select[0]);
   COV_SUSPEND_WAKE: cover property (memDrive);
   COV_SOFT_IRQ: cover property (sys_status_level1_a[11] ##1 core_irq_level0);
   COV_GROUP_B: cover property (core_irq_level0 && activeB != 16'h0000);

endmodule // tlic_top
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the two-level interrupt collector
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clock = 1'b0, nrst = 1'b0, suspendMode = 1'b0, regRead = 1'b0, regWrite = 1'b0;
   logic        regRdValid, irq0, irq1, irq2, nmi, anyAll, memDrive;
   logic        ce = 1'b1;
   logic [31:0] regAddr = 32'h0;
   logic [15:0] regWdata = 16'h0, regRdata, reqCmd = 16'h0, rq;
   int          err_count = 0, checks = 0, mdCount = 0;
   tlic_periph_model periph_u (.clock(clock), .nrst(nrst), .reqCmd(reqCmd), .reqLine(rq));
   tlic_top dut_u (.clock(clock), .nrst(nrst), .ce(ce), .suspendMode(suspendMode),
      .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite), .regWdata(regWdata),
      .regRdata(regRdata), .regRdValid(regRdValid), .battery_low_request(rq[0]),
      .power_switch_request(rq[1]), .rtc_long_one_line(rq[2]), .elapsed_timer_request(rq[3]),
      .clock_run_request(rq[4]), .serial_unit_request(rq[5]), .rtc_long_two_line(rq[6]),
      .ledRequest(rq[7]), .tclkRequest(rq[8]), .gpioLowReq({16{rq[9]}}),
      .gpioHighReq({16{rq[10]}}), .debug_serial_request(rq[11]), .infraredReq({5{rq[12]}}),
      .pciRequest(rq[13]), .scuRequest(rq[14]), .syncSerialReq({8{rq[15]}}),
      .busCtrlRequest(rq[15]), .core_irq_level0(irq0), .core_irq_level1(irq1),
      .core_irq_level2(irq2), .coreNmi(nmi), .anyIrqAll(anyAll), .memDrive(memDrive));
   initial forever #25 clock = ~clock;
   always @(posedge clock) if (memDrive === 1'b1) mdCount++;
   initial #200000 finish_test(1);
   task automatic chk(input string name, input logic [16:0] seen, input logic [16:0] exp);
      checks++;
      err_count += (seen !== exp);
      if (seen !== exp) $display("BAD %s expected %h seen %h", name, exp, seen);
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge clock) #2;
      regAddr = {24'h0f0000, a};
      regWdata = d;
      {regWrite, regRead} = {w, !w};
      @(posedge clock) #2;
      {regWrite, regRead} = 2'b00;
      if (!w) chk("read", {regRdValid, regRdata}, {1'b1, d});
   endtask
   // Four edges: partner flop, pending flop, output flop, then settle
   task automatic req(input logic [15:0] c, input logic [3:0] exp);
      reqCmd = c;
      repeat (4) @(posedge clock);
      #2;
      chk("irqOut", {12'h0, irq0, irq1, irq2, nmi, anyAll}, {12'h0, exp, |exp});
   endtask
   task automatic finish_test(input int late);
      err_count += late;
      if (err_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic scnRouting;
      req(16'h0044, 4'b0000);
      acc(0, 8'h80, 16'h0004);
      acc(1, 8'h8c, 16'hffff);
      acc(0, 8'h8c, 16'h1b0f);
      acc(1, 8'ha6, 16'h0001);
      req(16'h0044, 4'b0110);
      req(16'h0001, 4'b0001);
      acc(1, 8'h98, 16'h0001);
      req(16'h0001, 4'b1000);
   endtask
   task automatic scnGroup;
      acc(1, 8'h8c, 16'h1b0e);
      req(16'h0200, 4'b0000);
      acc(0, 8'h88, 16'hbfff);
      acc(1, 8'h94, 16'hffff);
      req(16'h0200, 4'b1000);
      acc(0, 8'h94, 16'hbfff);
      acc(0, 8'h80, 16'h0100);
      req(16'h0800, 4'b0000);
      acc(0, 8'h8a, 16'h0800);
   endtask
   // Soft request must be cleared again, or the suspend wake edge is hidden
   task automatic scnSoft;
      acc(1, 8'h9a, 16'h0001);
      req(16'h0000, 4'b1000);
      acc(0, 8'h80, 16'h0800);
      acc(1, 8'h80, 16'hffff);
      acc(0, 8'h80, 16'h0800);
      acc(0, 8'h90, 16'h0000);
      acc(1, 8'h9a, 16'h0000);
      suspendMode = 1'b1;
      req(16'h0004, 4'b0100);
      chk("memDrive", 17'(mdCount), 17'h00001);
   endtask
   // Second first-level group, then a clock-enable freeze; suspend is still high here
   task automatic scnLevelB;
      acc(1, 8'h8c, 16'h0000);
      acc(1, 8'ha6, 16'hffff);
      acc(0, 8'ha6, 16'h03fb);
      req(16'h0180, 4'b1000);
      chk("memDrive", 17'(mdCount), 17'h00002);
      acc(0, 8'ha0, 16'h000a);
      req(16'hf400, 4'b0000);
      acc(0, 8'ha2, 16'hffff);
      acc(0, 8'hb0, 16'h00ff);
      acc(1, 8'ha8, 16'hffff);
      acc(1, 8'haa, 16'hffff);
      acc(1, 8'hb2, 16'hffff);
      acc(1, 8'hb4, 16'hffff);
      acc(1, 8'hb6, 16'hffff);
      acc(1, 8'hba, 16'hffff);
      acc(0, 8'haa, 16'h001f);
      acc(0, 8'ha0, 16'h03d0);
      acc(0, 8'h80, 16'h0100);
      req(16'hf400, 4'b1000);
      ce = 1'b0;
      req(16'h0000, 4'b1000);
      ce = 1'b1;
      req(16'h0000, 4'b0000);
   endtask
   initial begin
      repeat (12) @(posedge clock);
      #2;
      nrst = 1'b1;
      scnRouting();
      scnGroup();
      scnSoft();
      scnLevelB();
      finish_test(0);
   end
endmodule // testbench
`default_nettype wire

// >>> tb/tlic_periph_model.sv
// Peripheral request sources on the far side of the collector
`timescale 1ns/1ps
`default_nettype none
module tlic_periph_model (
   // System
   input  wire logic        clock,
   input  wire logic        nrst,
   // Pattern from the bench and request levels
   input  wire logic [15:0] reqCmd,
   output var  logic [15:0] reqLine
);
   // Sources hold a request as a level until they withdraw it
   always_ff @(posedge clock or negedge nrst)
      if (!nrst) reqLine <= 16'h0000;
      else reqLine <= reqCmd;
endmodule // tlic_periph_model
`default_nettype wire
